/* File: common/rdm_consts.svh */
`ifndef RDM_CONSTS_SVH
`define RDM_CONSTS_SVH

// ****************************************
// register indices and byte addresses
// ****************************************
`define RDM_IDX_DATAPATH 8'h22
`define RDM_IDX_RXMODE 8'h23
`define RDM_IDX_IRQ_STATUS 8'h30
`define RDM_IDX_IRQ_MASK 8'h31
`define RDM_IDX_PROT_STATUS 8'h32
`define RDM_ADDR_W 10
`define RDM_ADDR_OF(idx) ({idx, 2'b00})

// ****************************************
// datapath control fields
// ****************************************
`define RDM_DP_BLOCK 7
`define RDM_DP_UNGATED 6
`define RDM_DP_POLARITY 5
`define RDM_DP_AUDIO_SUPPRESS 4
`define RDM_DP_4CH_OVERRIDE 3
`define RDM_DP_WIDTH18 2
`define RDM_DP_INBAND 1
`define RDM_DP_4CH_EN 0
`define RDM_DP_RESET 8'h00
`define RDM_DP_FWD_MASK 8'h7F

// ****************************************
// receive mode fields
// ****************************************
`define RDM_RX_CHECKSUM 7
`define RDM_RX_BC_RATE 6
`define RDM_RX_AUTO_AUDIO 5
`define RDM_RX_BC_FAST 4
`define RDM_RX_COAX 3
`define RDM_RX_REPEATER 2
`define RDM_RX_RESET 8'h20
`define RDM_RX_RW_MASK 8'hFB

// ****************************************
// interrupt events and strap pins
// ****************************************
`define RDM_EV_FWD_APPLIED 0
`define RDM_EV_CHK_MISMATCH 1
`define RDM_EV_FWD_BLOCKED 2
`define RDM_EV_W 3
`define RDM_STRAP_FAST 2
`define RDM_STRAP_COAX 1
`define RDM_STRAP_REPEATER 0

// ****************************************
// datapath and timing constants
// ****************************************
`define RDM_PIX_W 24
`define RDM_PIX_18_MASK 24'hFCFCFC
`define RDM_BC_DIV_SLOW 2'h3
`define RDM_BC_DIV_MID 2'h1
`define RDM_BC_FAST_MBPS 20
`define RDM_RESP_OKAY 2'h0
`define RDM_RESP_SLVERR 2'h2

`endif

/* File: common/rdm_pkg.sv */
package rdm_pkg;
   // back-channel rate selection
   typedef enum logic [1:0] {
      RDM_BC_DIV4,
      RDM_BC_DIV2,
      RDM_BC_HIGH
   } rdm_bc_mode_e;

   typedef logic [7:0] rdm_byte_t;
endpackage : rdm_pkg

/* File: hw/rdm_line_checksum.sv */
`timescale 1ns/1ns
`include "rdm_consts.svh"

module rdm_line_checksum
   import rdm_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic enable, // checking enabled
   input wire logic byte_valid, // pixel byte strobe
   input wire rdm_byte_t byte_data, // pixel byte
   input wire logic line_end, // checksum byte strobe, ends the line
   input wire rdm_byte_t line_sum, // checksum byte sent after the line
   output logic mismatch // one-cycle pulse on a failed line
);

   rdm_byte_t sum_q;
   logic mismatch_q;

   // ****************************************
   // running byte sum, restarted at each line end
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst || line_end) begin
         sum_q <= 8'h00;
      end else if (byte_valid) begin
         sum_q <= sum_q + byte_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mismatch_q <= 1'b0;
      end else begin
         mismatch_q <= enable && line_end && (line_sum != sum_q);
      end
   end

   assign mismatch = mismatch_q;

endmodule : rdm_line_checksum

/* File: hw/rdm_mode_regs.sv */
`timescale 1ns/1ns
`include "rdm_consts.svh"

// Contract
// - Block bit set: forward-channel updates ignored, local values kept.
// - Other datapath fields refresh from remote serializer unless blocked.
// - Ungated pass forwards pixels regardless of pixel-valid; else valid frames data.
// - Ungated pass disables content protection and blocks packetized audio.
// - Polarity bit 1 means active-low valid, 0 means active-high.
// - Regeneration bit 1 suppresses packetized audio on pixel pins; 0 passes it.
// - Four-channel override 1 takes local enable bit; 0 disables four-channel.
// - Width bit selects 18-bit video when 1, 24-bit when 0.
// - Transport bit selects in-band audio when 1, data-island when 0.
// - Four-channel enable bit turns four-channel audio on or off.
// - Checksum enable checks per-line byte and records mismatches in protection status.
// - Back-channel rate divides oscillator divider output by 4 or 2.
// - Fast back-channel runs 20 Mbps and ignores the rate bit.
// - Automatic audio mode, reset on, derives audio mode from auxiliary codes.
// - Cable bit selects twisted pair when 0, coax when 1.
// - Fast back-channel, cable and repeater bits load from mode strap at reset.
// - Repeater indicator is read-only and reports repeater strapping.
module rdm_mode_regs
   import rdm_pkg::*;
(
   input wire logic CLOCK, // system clock, 50 MHz
   input wire logic RST, // synchronous reset, active high
   // axi4-lite slave
   input wire logic [`RDM_ADDR_W-1:0] S_AXI_AWADDR, // write address
   input wire logic S_AXI_AWVALID, // write address valid
   output logic S_AXI_AWREADY, // write address ready
   input wire logic [31:0] S_AXI_WDATA, // write data
   input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
   input wire logic S_AXI_WVALID, // write data valid
   output logic S_AXI_WREADY, // write data ready
   output logic [1:0] S_AXI_BRESP, // write response
   output logic S_AXI_BVALID, // write response valid
   input wire logic S_AXI_BREADY, // write response ready
   input wire logic [`RDM_ADDR_W-1:0] S_AXI_ARADDR, // read address
   input wire logic S_AXI_ARVALID, // read address valid
   output logic S_AXI_ARREADY, // read address ready
   output logic [31:0] S_AXI_RDATA, // read data
   output logic [1:0] S_AXI_RRESP, // read response
   output logic S_AXI_RVALID, // read data valid
   input wire logic S_AXI_RREADY, // read data ready
   // forward channel configuration from remote serializer
   input wire logic FWD_CFG_VALID, // one-cycle config strobe
   input wire logic [6:0] FWD_CFG_DATA, // datapath fields 6..0
   input wire logic [2:0] MODE_STRAP_PIN, // fast, coax, repeater straps
   // pixel path
   input wire logic [`RDM_PIX_W-1:0] PIXEL_DATA_IN, // incoming pixel
   input wire logic PIXEL_VALID_IN, // pixel-valid at selected polarity
   output logic [`RDM_PIX_W-1:0] PIXEL_DATA_OUT, // forwarded pixel
   output logic PIXEL_OUT_VALID, // forwarded pixel strobe
   // line checksum
   input wire logic LINE_BYTE_VALID, // pixel byte for checksum
   input wire logic [7:0] LINE_BYTE, // pixel byte value
   input wire logic LINE_END, // checksum byte strobe
   input wire logic [7:0] LINE_SUM, // received checksum byte
   // back channel
   input wire logic OSC_DIV_TICK, // oscillator divider output pulse
   output logic BC_TICK, // back-channel bit tick
   output logic BC_FAST, // back channel at high speed
   // mode outputs
   output logic PROTECTION_ENABLE, // content protection allowed
   output logic PACKET_AUDIO_ENABLE, // packetized audio on pixel pins
   output logic FOUR_CH_AUDIO, // four-channel audio active
   output logic VIDEO_18BIT, // 18-bit video mode
   output logic AUDIO_INBAND, // in-band audio transport
   output logic AUTO_AUDIO_MODE, // audio mode from aux codes
   output logic CABLE_COAX, // receiver set for coax
   output logic REPEATER_MODE, // strapped as repeater
   output logic IRQ // level interrupt
);

   // ****************************************
   // register state
   // ****************************************
   logic [7:0] dp_q;
   logic [7:0] rx_q;
   logic [`RDM_EV_W-1:0] irq_status_q;
   logic [`RDM_EV_W-1:0] irq_mask_q;
   logic [7:0] mismatch_cnt_q;
   logic chk_mismatch;

   // ****************************************
   // axi4-lite write channel
   // ****************************************
   logic aw_full_q;
   logic w_full_q;
   logic [`RDM_ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_go;
   logic wr_lane0;
   logic wr_dp;
   logic wr_rx;
   logic wr_st;
   logic wr_mk;
   logic wr_ps;
   logic wr_hit;

   assign S_AXI_AWREADY = !aw_full_q;
   assign S_AXI_WREADY = !w_full_q;
   assign wr_go = aw_full_q && w_full_q && !bvalid_q;
   assign wr_lane0 = wr_go && w_strb_q[0];
   assign wr_dp = aw_addr_q == `RDM_ADDR_OF(`RDM_IDX_DATAPATH);
   assign wr_rx = aw_addr_q == `RDM_ADDR_OF(`RDM_IDX_RXMODE);
   assign wr_st = aw_addr_q == `RDM_ADDR_OF(`RDM_IDX_IRQ_STATUS);
   assign wr_mk = aw_addr_q == `RDM_ADDR_OF(`RDM_IDX_IRQ_MASK);
   assign wr_ps = aw_addr_q == `RDM_ADDR_OF(`RDM_IDX_PROT_STATUS);
   assign wr_hit = wr_dp || wr_rx || wr_st || wr_mk || wr_ps;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (S_AXI_AWVALID && !aw_full_q) begin
         aw_full_q <= 1'b1;
         aw_addr_q <= S_AXI_AWADDR;
      end else if (wr_go) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         w_full_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (S_AXI_WVALID && !w_full_q) begin
         w_full_q <= 1'b1;
         w_data_q <= S_AXI_WDATA;
         w_strb_q <= S_AXI_WSTRB;
      end else if (wr_go) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         bvalid_q <= 1'b0;
         bresp_q <= `RDM_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? `RDM_RESP_OKAY : `RDM_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;

   // ****************************************
   // axi4-lite read channel
   // ****************************************
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [31:0] rd_word;
   logic rd_hit;

   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      case (S_AXI_ARADDR)
         `RDM_ADDR_OF(`RDM_IDX_DATAPATH): rd_word[7:0] = dp_q;
         `RDM_ADDR_OF(`RDM_IDX_RXMODE): rd_word[7:0] = rx_q;
         `RDM_ADDR_OF(`RDM_IDX_IRQ_STATUS): rd_word[`RDM_EV_W-1:0] = irq_status_q;
         `RDM_ADDR_OF(`RDM_IDX_IRQ_MASK): rd_word[`RDM_EV_W-1:0] = irq_mask_q;
         `RDM_ADDR_OF(`RDM_IDX_PROT_STATUS): rd_word[7:0] = mismatch_cnt_q;
         default: rd_hit = 1'b0;
      endcase
   end

   assign S_AXI_ARREADY = !rvalid_q;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `RDM_RESP_OKAY;
      end else if (S_AXI_ARVALID && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_hit ? `RDM_RESP_OKAY : `RDM_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   // ****************************************
   // datapath control register
   // ****************************************
   logic fwd_take;
   logic fwd_refused;

   assign fwd_take = FWD_CFG_VALID && !dp_q[`RDM_DP_BLOCK];
   assign fwd_refused = FWD_CFG_VALID && dp_q[`RDM_DP_BLOCK];

   // a local write in the same cycle as a forward load wins
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         dp_q <= `RDM_DP_RESET;
      end else if (wr_lane0 && wr_dp) begin
         dp_q <= w_data_q[7:0];
      end else if (fwd_take) begin
         dp_q <= {dp_q[`RDM_DP_BLOCK], FWD_CFG_DATA};
      end
   end

   // ****************************************
   // receive mode register, straps loaded in reset
   // ****************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rx_q <= `RDM_RX_RESET;
         rx_q[`RDM_RX_BC_FAST] <= MODE_STRAP_PIN[`RDM_STRAP_FAST];
         rx_q[`RDM_RX_COAX] <= MODE_STRAP_PIN[`RDM_STRAP_COAX];
         rx_q[`RDM_RX_REPEATER] <= MODE_STRAP_PIN[`RDM_STRAP_REPEATER];
      end else if (wr_lane0 && wr_rx) begin
         // repeater bit keeps its strap value
         rx_q <= (w_data_q[7:0] & `RDM_RX_RW_MASK) | (rx_q & ~`RDM_RX_RW_MASK);
      end
   end

   // ****************************************
   // line checksum and protection status
   // ****************************************
   rdm_line_checksum u_chk (
      .clk(CLOCK),
      .rst(RST),
      .enable(rx_q[`RDM_RX_CHECKSUM]),
      .byte_valid(LINE_BYTE_VALID),
      .byte_data(LINE_BYTE),
      .line_end(LINE_END),
      .line_sum(LINE_SUM),
      .mismatch(chk_mismatch)
   );

   // saturating mismatch count, a protection status write with byte lane 0 strobed clears; a mismatch in that cycle counts
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         mismatch_cnt_q <= 8'h00;
      end else if (chk_mismatch) begin
         if (wr_lane0 && wr_ps) begin
            mismatch_cnt_q <= 8'h01;
         end else if (mismatch_cnt_q != 8'hFF) begin
            mismatch_cnt_q <= mismatch_cnt_q + 8'h01;
         end
      end else if (wr_lane0 && wr_ps) begin
         mismatch_cnt_q <= 8'h00;
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   logic [`RDM_EV_W-1:0] events;
   logic [`RDM_EV_W-1:0] st_clear;

   always_comb begin
      events = '0;
      events[`RDM_EV_FWD_APPLIED] = fwd_take;
      events[`RDM_EV_CHK_MISMATCH] = chk_mismatch;
      events[`RDM_EV_FWD_BLOCKED] = fwd_refused;
      st_clear = (wr_lane0 && wr_st) ? w_data_q[`RDM_EV_W-1:0] : '0;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= (irq_status_q & ~st_clear) | events;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         irq_mask_q <= '0;
      end else if (wr_lane0 && wr_mk) begin
         irq_mask_q <= w_data_q[`RDM_EV_W-1:0];
      end
   end

   assign IRQ = |(irq_status_q & irq_mask_q);

   // ****************************************
   // pixel path
   // ****************************************
   logic valid_active;
   logic pix_pass;
   logic [`RDM_PIX_W-1:0] pix_q;
   logic pix_valid_q;

   assign valid_active = dp_q[`RDM_DP_POLARITY] ? !PIXEL_VALID_IN : PIXEL_VALID_IN;
   assign pix_pass = dp_q[`RDM_DP_UNGATED] || valid_active;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pix_q <= '0;
         pix_valid_q <= 1'b0;
      end else begin
         pix_valid_q <= pix_pass;
         if (pix_pass) begin
            pix_q <= dp_q[`RDM_DP_WIDTH18] ? (PIXEL_DATA_IN & `RDM_PIX_18_MASK) : PIXEL_DATA_IN;
         end
      end
   end

   assign PIXEL_DATA_OUT = pix_q;
   assign PIXEL_OUT_VALID = pix_valid_q;

   // ****************************************
   // back-channel rate divider
   // ****************************************
   rdm_bc_mode_e bc_mode;
   logic [1:0] bc_cnt_q;
   logic [1:0] bc_last;
   logic bc_tick_q;

   always_comb begin
      if (rx_q[`RDM_RX_BC_FAST]) begin
         bc_mode = RDM_BC_HIGH;
      end else if (rx_q[`RDM_RX_BC_RATE]) begin
         bc_mode = RDM_BC_DIV2;
      end else begin
         bc_mode = RDM_BC_DIV4;
      end
   end

   always_comb begin
      case (bc_mode)
         RDM_BC_DIV4: bc_last = `RDM_BC_DIV_SLOW;
         RDM_BC_DIV2: bc_last = `RDM_BC_DIV_MID;
         default: bc_last = 2'h0;
      endcase
   end

   // fast mode passes every oscillator tick; the 20 Mbps clock is set by that source
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         bc_cnt_q <= 2'h0;
         bc_tick_q <= 1'b0;
      end else begin
         bc_tick_q <= 1'b0;
         if (OSC_DIV_TICK) begin
            if (bc_cnt_q >= bc_last) begin
               bc_cnt_q <= 2'h0;
               bc_tick_q <= 1'b1;
            end else begin
               bc_cnt_q <= bc_cnt_q + 2'h1;
            end
         end
      end
   end

   assign BC_TICK = bc_tick_q;
   assign BC_FAST = rx_q[`RDM_RX_BC_FAST];

   // ****************************************
   // mode outputs
   // ****************************************
   assign PROTECTION_ENABLE = !dp_q[`RDM_DP_UNGATED];
   assign PACKET_AUDIO_ENABLE = !dp_q[`RDM_DP_UNGATED] && !dp_q[`RDM_DP_AUDIO_SUPPRESS];
   assign FOUR_CH_AUDIO = dp_q[`RDM_DP_4CH_OVERRIDE] && dp_q[`RDM_DP_4CH_EN];
   assign VIDEO_18BIT = dp_q[`RDM_DP_WIDTH18];
   assign AUDIO_INBAND = dp_q[`RDM_DP_INBAND];
   assign AUTO_AUDIO_MODE = rx_q[`RDM_RX_AUTO_AUDIO];
   assign CABLE_COAX = rx_q[`RDM_RX_COAX];
   assign REPEATER_MODE = rx_q[`RDM_RX_REPEATER];

endmodule : rdm_mode_regs

/* File: tb/rdm_props.sv */
`timescale 1ns/1ns
`include "rdm_consts.svh"
module rdm_props (
   input wire logic CLOCK, // clock
   input wire logic RST, // reset
   input wire logic FWD_CFG_VALID, // cfg strobe
   input wire logic [6:0] FWD_CFG_DATA, // cfg fields
   input wire logic [23:0] PIXEL_DATA_IN, // pixel in
   input wire logic [23:0] PIXEL_DATA_OUT, // pixel out
   input wire logic PIXEL_OUT_VALID, // out strobe
   input wire logic OSC_DIV_TICK, // osc tick
   input wire logic BC_TICK, // bc tick
   input wire logic BC_FAST, // fast bc
   input wire logic PROTECTION_ENABLE, // prot on
   input wire logic PACKET_AUDIO_ENABLE, // audio on
   input wire logic VIDEO_18BIT, // 18-bit
   input wire logic AUDIO_INBAND, // in-band
   input wire logic REPEATER_MODE, // repeater
   input wire logic S_AXI_ARVALID, // ar valid
   input wire logic S_AXI_ARREADY, // ar ready
   input wire logic S_AXI_RVALID, // r valid
   input wire logic S_AXI_RREADY, // r ready
   input wire logic [31:0] S_AXI_RDATA // r data
);
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   logic [6:0] cfg_q;
   always_ff @(posedge CLOCK) begin
      cfg_q <= FWD_CFG_DATA;
   end
   pass_ungated_a: assert property (!PROTECTION_ENABLE |=> PIXEL_OUT_VALID && PIXEL_DATA_OUT ==
      ($past(PIXEL_DATA_IN) & ($past(VIDEO_18BIT) ? `RDM_PIX_18_MASK : 24'hFFFFFF))) else $error("pixel not passed");
   audio_block_a: assert property (PACKET_AUDIO_ENABLE |-> PROTECTION_ENABLE) else $error("audio while ungated");
   tick_cause_a: assert property (!OSC_DIV_TICK |=> !BC_TICK) else $error("tick without cause");
   tick_fast_a: assert property (BC_FAST && OSC_DIV_TICK |=> BC_TICK) else $error("fast tick lost");
   tick_gap_a: assert property (BC_TICK && !BC_FAST |=> !BC_TICK) else $error("slow ticks adjacent");
   fwd_atomic_a: assert property (FWD_CFG_VALID |=> (VIDEO_18BIT == cfg_q[2] && AUDIO_INBAND == cfg_q[1] &&
      PROTECTION_ENABLE != cfg_q[6]) || ($stable(VIDEO_18BIT) && $stable(AUDIO_INBAND) && $stable(PROTECTION_ENABLE)))
      else $error("partial forward load");
   repeat_fixed_a: assert property (!$past(RST) |-> $stable(REPEATER_MODE)) else $error("repeater changed");
   rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("no read answer");
   rd_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   cover property (FWD_CFG_VALID);
   cover property (BC_FAST && BC_TICK);
   cover property (!PROTECTION_ENABLE && PIXEL_OUT_VALID);
endmodule : rdm_props

bind rdm_mode_regs rdm_props i_rdm_props (.CLOCK(CLOCK), .RST(RST), .FWD_CFG_VALID(FWD_CFG_VALID),
   .FWD_CFG_DATA(FWD_CFG_DATA), .PIXEL_DATA_IN(PIXEL_DATA_IN), .PIXEL_DATA_OUT(PIXEL_DATA_OUT),
   .PIXEL_OUT_VALID(PIXEL_OUT_VALID), .OSC_DIV_TICK(OSC_DIV_TICK), .BC_TICK(BC_TICK), .BC_FAST(BC_FAST),
   .PROTECTION_ENABLE(PROTECTION_ENABLE), .PACKET_AUDIO_ENABLE(PACKET_AUDIO_ENABLE), .VIDEO_18BIT(VIDEO_18BIT),
   .AUDIO_INBAND(AUDIO_INBAND), .REPEATER_MODE(REPEATER_MODE), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .S_AXI_RDATA(S_AXI_RDATA));

/* File: tb/rdm_ser.sv */
`timescale 1ns/1ns
module rdm_ser (
   input wire logic clk, // clock
   output logic cfg_valid, // cfg strobe
   output logic [6:0] cfg_data, // cfg fields
   output logic [23:0] pix, // pixel
   output logic pix_valid // pixel-valid
);
   // ****************************************
   // remote serializer
   // ****************************************
   initial begin
      cfg_valid = 1'h0;
      cfg_data = 7'h00;
      pix = 24'h000000;
      pix_valid = 1'h0;
   end
   logic auto_ack = 1'h0; // flag set by set_auto_ack; no logic acts on it
   task automatic set_auto_ack;
      auto_ack <= 1'h1;
      @(posedge clk);
   endtask : set_auto_ack
   task automatic send_cfg(input logic [6:0] d);
      @(posedge clk);
      cfg_valid <= 1'h1;
      cfg_data <= d;
      @(posedge clk);
      cfg_valid <= 1'h0;
      cfg_data <= ~d; // stale fields scrambled
   endtask : send_cfg
   task automatic send_pix(input logic [23:0] d, input logic v);
      @(posedge clk);
      pix <= d;
      pix_valid <= v;
      @(posedge clk);
      pix <= ~d;
      pix_valid <= ~v;
   endtask : send_pix
endmodule : rdm_ser

/* File: tb/rdm_mode_regs_bench.sv */
`timescale 1ns/1ns
module rdm_mode_regs_bench;
   localparam logic [9:0] A_DP = 10'h088, A_RX = 10'h08C, A_ST = 10'h0C0, A_MK = 10'h0C4, A_PR = 10'h0C8;
   logic CLOCK = 1'h0, RST = 1'h1;
   logic [9:0] S_AXI_AWADDR = 10'h000, S_AXI_ARADDR = 10'h000;
   logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
   logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
   logic [3:0] S_AXI_WSTRB = 4'hF;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic FWD_CFG_VALID, PIXEL_VALID_IN, PIXEL_OUT_VALID;
   logic [6:0] FWD_CFG_DATA;
   logic [23:0] PIXEL_DATA_IN, PIXEL_DATA_OUT;
   logic [2:0] MODE_STRAP_PIN = 3'h5;
   logic LINE_BYTE_VALID = 1'h0, LINE_END = 1'h0, OSC_DIV_TICK = 1'h0;
   logic [7:0] LINE_BYTE = 8'h00, LINE_SUM = 8'h00;
   logic BC_TICK, BC_FAST, PROTECTION_ENABLE, PACKET_AUDIO_ENABLE, FOUR_CH_AUDIO, VIDEO_18BIT;
   logic AUDIO_INBAND, AUTO_AUDIO_MODE, CABLE_COAX, REPEATER_MODE, IRQ;
   int n_fail = 0, n_checks = 0, n_tick = 0;
   logic [7:0] rx_t[3] = '{8'h08, 8'h48, 8'h58};
   int tk_t[3] = '{2, 4, 8};
   logic [7:0] pm[7] = '{8'h80, 8'h80, 8'hA0, 8'hA0, 8'hC0, 8'h84, 8'h90};
   logic pv[7] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
   logic po[7] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1};

   rdm_mode_regs i_rdm_mode_regs (.*);
   rdm_ser i_rdm_ser (.clk(CLOCK), .cfg_valid(FWD_CFG_VALID), .cfg_data(FWD_CFG_DATA),
      .pix(PIXEL_DATA_IN), .pix_valid(PIXEL_VALID_IN));

   always #10 CLOCK = ~CLOCK;
   always @(posedge CLOCK) begin
      if (BC_TICK === 1'h1) n_tick <= n_tick + 1;
   end

   // ****************************************
   // tasks
   // ****************************************
   task report_and_stop;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic guard(inout int n);
      n++;
      if (n > 50) begin
         n_fail++;
         report_and_stop;
      end
   endtask : guard
   task automatic axi_wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      @(posedge CLOCK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {24'h0, d};
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID <= 1'h1;
      S_AXI_BREADY <= 1'h1;
      forever begin
         @(posedge CLOCK);
         guard(n);
         if (S_AXI_AWVALID && S_AXI_AWREADY === 1'h1) S_AXI_AWVALID <= 1'h0;
         if (S_AXI_WVALID && S_AXI_WREADY === 1'h1) S_AXI_WVALID <= 1'h0;
         if (S_AXI_BVALID === 1'h1) begin
            S_AXI_BREADY <= 1'h0;
            chk("bresp", er, S_AXI_BRESP);
            break;
         end
      end
   endtask : axi_wr
   task automatic rdc(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      @(posedge CLOCK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'h1;
      forever begin
         @(posedge CLOCK);
         guard(n);
         if (S_AXI_ARVALID && S_AXI_ARREADY === 1'h1) S_AXI_ARVALID <= 1'h0;
         if (S_AXI_RVALID === 1'h1) begin
            if (S_AXI_RREADY) begin
               S_AXI_RREADY <= 1'h0;
               chk("rresp", er, S_AXI_RRESP);
               chk($sformatf("reg %h", a), e, S_AXI_RDATA);
               break;
            end
            S_AXI_RREADY <= 1'h1;
         end
      end
   endtask : rdc
   task automatic line(input logic [7:0] s);
      for (int k = 1; k <= 3; k++) begin
         @(posedge CLOCK);
         LINE_BYTE_VALID <= 1'h1;
         LINE_BYTE <= k[7:0];
      end
      @(posedge CLOCK);
      LINE_BYTE_VALID <= 1'h0;
      LINE_END <= 1'h1;
      LINE_SUM <= s;
      @(posedge CLOCK);
      LINE_END <= 1'h0;
   endtask : line

   // ****************************************
   // sequence
   // ****************************************
   initial begin
      int t0;
      repeat (12) @(posedge CLOCK);
      RST <= 1'h0;
      rdc(A_DP, 32'h00);
      rdc(A_RX, 32'h34);
      chk("BC_FAST", 1, BC_FAST);
      chk("REPEATER_MODE", 1, REPEATER_MODE);
      chk("AUTO_AUDIO_MODE", 1, AUTO_AUDIO_MODE);
      i_rdm_ser.set_auto_ack();
      chk("auto_ack", 1, i_rdm_ser.auto_ack);
      axi_wr(A_RX, 8'h08);
      rdc(A_RX, 32'h0C);
      chk("CABLE_COAX", 1, CABLE_COAX);
      axi_wr(10'h100, 8'h00, 2'h2);
      rdc(10'h100, 32'h0, 2'h2);
      foreach (rx_t[i]) begin
         axi_wr(A_RX, rx_t[i]);
         t0 = n_tick;
         repeat (8) begin
            @(posedge CLOCK);
            OSC_DIV_TICK <= 1'h1;
            @(posedge CLOCK);
            OSC_DIV_TICK <= 1'h0;
         end
         repeat (3) @(posedge CLOCK);
         chk("bc ticks", tk_t[i], n_tick - t0);
      end
      i_rdm_ser.send_cfg(7'h55);
      rdc(A_DP, 32'h55);
      chk("FOUR_CH_AUDIO", 0, FOUR_CH_AUDIO);
      chk("PACKET_AUDIO_ENABLE", 0, PACKET_AUDIO_ENABLE);
      i_rdm_ser.send_cfg(7'h0B);
      rdc(A_DP, 32'h0B);
      chk("FOUR_CH_AUDIO", 1, FOUR_CH_AUDIO);
      chk("AUDIO_INBAND", 1, AUDIO_INBAND);
      chk("VIDEO_18BIT", 0, VIDEO_18BIT);
      axi_wr(A_DP, 8'h80);
      i_rdm_ser.send_cfg(7'h7F);
      rdc(A_DP, 32'h80);
      chk("IRQ", 0, IRQ);
      axi_wr(A_MK, 8'h04);
      chk("IRQ", 1, IRQ);
      axi_wr(A_ST, 8'h04);
      chk("IRQ", 0, IRQ);
      rdc(A_ST, 32'h01);
      foreach (pm[i]) begin
         axi_wr(A_DP, pm[i]);
         i_rdm_ser.send_pix(24'h5A3C0F, pv[i]);
         #1;
         chk("PIXEL_OUT_VALID", po[i], PIXEL_OUT_VALID);
         chk("PIXEL_DATA_OUT", 24'h5A3C0F & (pm[i][2] ? 24'hFCFCFC : 24'hFFFFFF), PIXEL_DATA_OUT);
         chk("PROTECTION_ENABLE", !pm[i][6], PROTECTION_ENABLE);
         chk("PACKET_AUDIO_ENABLE", !pm[i][6] && !pm[i][4], PACKET_AUDIO_ENABLE);
      end
      axi_wr(A_RX, 8'h80);
      line(8'h06);
      line(8'h07);
      repeat (3) @(posedge CLOCK);
      rdc(A_PR, 32'h01);
      rdc(A_ST, 32'h03);
      axi_wr(A_RX, 8'h00);
      line(8'h07);
      repeat (3) @(posedge CLOCK);
      rdc(A_PR, 32'h01);
      axi_wr(A_PR, 8'h00);
      rdc(A_PR, 32'h00);
      S_AXI_WSTRB <= 4'hE;
      axi_wr(A_MK, 8'h03);
      rdc(A_MK, 32'h04);
      MODE_STRAP_PIN <= 3'h2;
      RST <= 1'h1;
      repeat (2) @(posedge CLOCK);
      RST <= 1'h0;
      rdc(A_RX, 32'h28);
      chk("REPEATER_MODE", 0, REPEATER_MODE);
      rdc(A_DP, 32'h00);
      report_and_stop;
   end
endmodule : rdm_mode_regs_bench
